// >>> design/ppc_pkg.sv
/*
  Constants for the per-port PHY control register bank: offsets, bit
  positions, reset values and the strap capture phase encoding.
  Assumes an 8-bit register port with byte addresses.
*/
package ppc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_P1_CTRL_B = 8'h1D;
  localparam logic [7:0] ADDR_P2_AN_CTRL = 8'h2C;
  localparam logic [7:0] ADDR_P2_CTRL_B = 8'h2D;
  localparam logic [7:0] ADDR_P3_RSV_AN = 8'h3C;
  localparam logic [7:0] ADDR_P3_RSV_CTRL = 8'h3D;

  // ----------------------------------------------------------------
  // Auto-negotiation control fields
  // ----------------------------------------------------------------
  localparam int AN_EN_BIT = 7;
  localparam int AN_SPEED_BIT = 6;
  localparam int AN_DUPLEX_BIT = 5;
  localparam int AN_PAUSE_BIT = 4;
  localparam int AN_ADV_MSB = 3;
  localparam logic [4:0] AN_ADV_RESET = 5'h1F;

  // ----------------------------------------------------------------
  // Second control register fields
  // ----------------------------------------------------------------
  localparam int CB_LED_OFF_BIT = 7;
  localparam int CB_TX_DIS_BIT = 6;
  localparam int CB_RESTART_BIT = 5;
  localparam int CB_FEF_DIS_BIT = 4;
  localparam int CB_PWR_DOWN_BIT = 3;
  localparam int CB_MDIX_DIS_BIT = 2;
  localparam int CB_FORCE_MDI_BIT = 1;
  localparam int CB_LOOPBACK_BIT = 0;
  localparam logic [7:0] CB_RESET = 8'h00;
  localparam logic [7:0] RSV_READ = 8'h00;

  // Strap capture phase, one-hot
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'h1,
    ST_RUN = 2'h2
  } ppc_phase_type;

endpackage

// >>> design/ppc_port_ctrl.sv
/*
  One PHY port's second control register and the controls it drives.
  Assumes writes qualified by the parent's address decode.
*/
`timescale 1ns/1ns
`default_nettype none

module ppc_port_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Register readback
  output logic [7:0] rd_value,
  // PHY controls
  output logic led_off,
  output logic tx_disable,
  output logic autoneg_restart,
  output logic fef_disable,
  output logic power_down,
  output logic auto_mdix_disable,
  output logic force_mdi,
  output logic loopback
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic restart;
  } ppc_port_state_type;

  ppc_port_state_type state_q, state_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Restart is a one-cycle pulse per write of one; stored bit reads back
  always_comb begin
    state_d = state_q;
    state_d.restart = 1'b0;
    if (wr_en) begin
      state_d.ctrl = wr_data;
      state_d.restart = wr_data[ppc_pkg::CB_RESTART_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '{ctrl: ppc_pkg::CB_RESET, restart: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_value = state_q.ctrl;
  assign led_off = state_q.ctrl[ppc_pkg::CB_LED_OFF_BIT];
  assign tx_disable = state_q.ctrl[ppc_pkg::CB_TX_DIS_BIT];
  assign autoneg_restart = state_q.restart;
  assign fef_disable = state_q.ctrl[ppc_pkg::CB_FEF_DIS_BIT];
  assign power_down = state_q.ctrl[ppc_pkg::CB_PWR_DOWN_BIT];
  assign auto_mdix_disable = state_q.ctrl[ppc_pkg::CB_MDIX_DIS_BIT];
  // Forced mode only matters with automatic crossover off
  assign force_mdi = state_q.ctrl[ppc_pkg::CB_FORCE_MDI_BIT];
  assign loopback = state_q.ctrl[ppc_pkg::CB_LOOPBACK_BIT];

endmodule

`default_nettype wire

// >>> design/ppc_phy_port_control_regs.sv
/*
  Per-port PHY control register bank: port 2 auto-negotiation control
  and the second control register of both PHY ports.
  Assumes a synchronous 8-bit register port on sys_clk, a clock that
  runs during reset, and strap pins stable for the last three clocks
  of reset.
*/
// Notes on behaviour
// - Autoneg enable set means negotiate; clear means forced speed and duplex.
// - With autoneg off, speed bit one gives 100BT, zero gives 10BT.
// - Duplex bit selects full or half when forced or negotiation fails.
// - Autoneg, speed and duplex reset values come from per-port strap pins.
// - Pause advertise bit; zero suppresses it; resets to one.
// - Bits 3..0 advertise 100F, 100H, 10F, 10H; each resets to one.
// - LED off bit drives both port LED pins high.
// - Transmitter disable bit turns off the port transmitter.
// - Writing one to restart bit restarts auto-negotiation.
// - Far-end fault disable turns off detection and pattern sending.
// - Bit 2 disables automatic MDI/MDI-X crossover.
// - With crossover off, bit 1 forces MDI, else MDI-X.
// - Loopback bit loops other port's traffic at this port's PHY.
`timescale 1ns/1ns
`default_nettype none

module ppc_phy_port_control_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Strap pins
  input wire logic port1_led_lo_strap,
  input wire logic port1_led_hi_strap,
  input wire logic mii_valid_strap,
  input wire logic mii_data3_strap,
  input wire logic mii_data2_strap,
  input wire logic mii_data1_strap,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Strap-derived port 1 defaults for its own register
  output logic p1_autoneg_en,
  output logic p1_force_100,
  output logic p1_force_full,
  // Port 2 negotiation controls
  output logic p2_autoneg_en,
  output logic p2_speed_100,
  output logic p2_duplex_full,
  output logic [4:0] p2_advertise,
  // LED pins, high means off
  input wire logic [1:0] p1_led_in,
  input wire logic [1:0] p2_led_in,
  output logic [1:0] p1_led,
  output logic [1:0] p2_led,
  // Port 1 PHY controls
  output logic p1_tx_disable,
  output logic p1_autoneg_restart,
  output logic p1_fef_disable,
  output logic p1_power_down,
  output logic p1_auto_mdix_disable,
  output logic p1_force_mdi,
  output logic p1_loopback,
  // Port 2 PHY controls
  output logic p2_tx_disable,
  output logic p2_autoneg_restart,
  output logic p2_fef_disable,
  output logic p2_power_down,
  output logic p2_auto_mdix_disable,
  output logic p2_force_mdi,
  output logic p2_loopback
);

  typedef struct packed {
    ppc_pkg::ppc_phase_type phase;
    logic [2:0] p1_strap;
    logic [7:0] p2_an;
    logic [7:0] rdata;
  } ppc_state_type;

  // Strap levels as they travel through the synchroniser
  typedef struct packed {
    logic [2:0] p1;
    logic an_en;
    logic speed;
    logic duplex;
  } ppc_strap_type;

  ppc_state_type state_q, state_d;
  ppc_strap_type strap_s1_q, strap_s2_q, strap_s3_q;
  logic strap_agree;
  logic [7:0] p1_cb, p2_cb;
  logic p1_led_off, p2_led_off;
  logic p1_wr, p2_wr;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    p1_wr = 1'b0;
    p2_wr = 1'b0;
    if (reg_wr && reg_addr == ppc_pkg::ADDR_P1_CTRL_B) begin
      p1_wr = 1'b1;
    end else if (reg_wr && reg_addr == ppc_pkg::ADDR_P2_CTRL_B) begin
      p2_wr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  // Three stages with no reset: straps are pins from outside the clock
  // domain and must be sampled while nrst is still low, so these flops
  // keep running through reset. Only stage two reads stage one.
  always_ff @(posedge sys_clk) begin
    strap_s1_q <= '{p1: {port1_led_lo_strap, port1_led_hi_strap,
                         mii_valid_strap},
                    an_en: mii_data3_strap,
                    speed: mii_data2_strap,
                    duplex: mii_data1_strap};
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
  end

  // A strap still settling keeps the bank in the capture phase
  assign strap_agree = (strap_s2_q == strap_s3_q);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Synchronised straps load at the first edge after release on which
  // the last two stages agree; a write to 0x2C on that edge is lost.
  always_comb begin
    state_d = state_q;
    case (state_q.phase)
      ppc_pkg::ST_CAPTURE: begin
        if (strap_agree) begin
          state_d.p1_strap = strap_s3_q.p1;
          state_d.p2_an[ppc_pkg::AN_EN_BIT] = strap_s3_q.an_en;
          state_d.p2_an[ppc_pkg::AN_SPEED_BIT] = strap_s3_q.speed;
          state_d.p2_an[ppc_pkg::AN_DUPLEX_BIT] = strap_s3_q.duplex;
          state_d.phase = ppc_pkg::ST_RUN;
        end
      end
      ppc_pkg::ST_RUN: begin
        if (reg_wr && reg_addr == ppc_pkg::ADDR_P2_AN_CTRL) begin
          state_d.p2_an = reg_wdata;
        end
      end
      default: state_d.phase = ppc_pkg::ST_RUN;
    endcase
    // Readback; unmapped and reserved slots read as zero
    if (reg_rd) begin
      if (reg_addr == ppc_pkg::ADDR_P2_AN_CTRL) begin
        state_d.rdata = state_q.p2_an;
      end else if (reg_addr == ppc_pkg::ADDR_P1_CTRL_B) begin
        state_d.rdata = p1_cb;
      end else if (reg_addr == ppc_pkg::ADDR_P2_CTRL_B) begin
        state_d.rdata = p2_cb;
      end else begin
        state_d.rdata = ppc_pkg::RSV_READ;
      end
    end
  end

  // Advertise bits reset to all ones; strap bits are loaded after release
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '{phase: ppc_pkg::ST_CAPTURE, p1_strap: 3'h0,
                   p2_an: {3'h0, ppc_pkg::AN_ADV_RESET},
                   rdata: 8'h00};
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Port control instances
  // ----------------------------------------------------------------
  // Port 1 second control register
  ppc_port_ctrl u_p1 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_en(p1_wr),
    .wr_data(reg_wdata),
    .rd_value(p1_cb),
    .led_off(p1_led_off),
    .tx_disable(p1_tx_disable),
    .autoneg_restart(p1_autoneg_restart),
    .fef_disable(p1_fef_disable),
    .power_down(p1_power_down),
    .auto_mdix_disable(p1_auto_mdix_disable),
    .force_mdi(p1_force_mdi),
    .loopback(p1_loopback)
  );

  // Port 2 second control register
  ppc_port_ctrl u_p2 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_en(p2_wr),
    .wr_data(reg_wdata),
    .rd_value(p2_cb),
    .led_off(p2_led_off),
    .tx_disable(p2_tx_disable),
    .autoneg_restart(p2_autoneg_restart),
    .fef_disable(p2_fef_disable),
    .power_down(p2_power_down),
    .auto_mdix_disable(p2_auto_mdix_disable),
    .force_mdi(p2_force_mdi),
    .loopback(p2_loopback)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state_q.rdata;
  assign p1_autoneg_en = state_q.p1_strap[2];
  assign p1_force_100 = state_q.p1_strap[1];
  assign p1_force_full = state_q.p1_strap[0];
  assign p2_autoneg_en = state_q.p2_an[ppc_pkg::AN_EN_BIT];
  assign p2_speed_100 = state_q.p2_an[ppc_pkg::AN_SPEED_BIT];
  assign p2_duplex_full = state_q.p2_an[ppc_pkg::AN_DUPLEX_BIT];
  assign p2_advertise = state_q.p2_an[ppc_pkg::AN_PAUSE_BIT:0];
  // LED pins forced high when switched off
  assign p1_led = p1_led_off ? 2'h3 : p1_led_in;
  assign p2_led = p2_led_off ? 2'h3 : p2_led_in;

endmodule

`default_nettype wire

// >>> tb/ppc_host_model.sv
/*
  Management host model driving the register port.
  Assumes the bench calls op() once per request, one request per edge.
*/
`timescale 1ns/1ns
`default_nettype none

module ppc_host_model (
  // Clock
  input wire logic sys_clk,
  // Register requests
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [7:0] reg_addr,
  output var logic [7:0] reg_wdata
);
  // Quiet port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Change 1 ns after an edge, hold until the next edge takes it
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    // Idle bus toggles so a stale value never looks valid
    if (!(w || r)) begin
      a = ~reg_addr;
      d = ~reg_wdata;
    end
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
  endtask
endmodule
`default_nettype wire

// >>> tb/ppc_phy_port_control_regs_assertions.sv
/*
  Checker for the PHY control register bank.
  Assumes the top module's port names; bound below.
*/
`timescale 1ns/1ns
`default_nettype none

module ppc_regs_checker (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Watched outputs
  input wire logic p2_autoneg_en,
  input wire logic p2_speed_100,
  input wire logic p2_duplex_full,
  input wire logic [4:0] p2_advertise,
  input wire logic [1:0] p1_led,
  input wire logic p2_tx_disable,
  input wire logic p2_autoneg_restart,
  input wire logic p1_fef_disable,
  input wire logic p2_power_down,
  input wire logic p2_loopback,
  input wire logic p1_auto_mdix_disable,
  input wire logic p1_force_mdi
);
  logic up_q;
  logic w2c;
  logic w1d;
  logic w2d;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Strap capture edge drops 0x2C writes, so it is skipped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
    end
  end
  assign w2c = up_q && reg_wr && reg_addr == 8'h2C;
  assign w1d = up_q && reg_wr && reg_addr == 8'h1D;
  assign w2d = up_q && reg_wr && reg_addr == 8'h2D;

  an_mode_a: assert property (w2c |=>
    {p2_autoneg_en, p2_speed_100, p2_duplex_full} == $past(reg_wdata[7:5]))
    else $error("negotiation mode wrong");
  advert_a: assert property (w2c |=>
    p2_advertise == $past(reg_wdata[4:0])) else $error("advertise wrong");
  led_off_a: assert property (w1d && reg_wdata[7] |=>
    (p1_led == 2'h3) [*2]) else $error("led not off");
  tx_dis_a: assert property (w2d |=>
    p2_tx_disable == $past(reg_wdata[6])) else $error("tx disable wrong");
  restart_a: assert property (w2d && reg_wdata[5] |=>
    p2_autoneg_restart ##1 !p2_autoneg_restart) else $error("restart bad");
  fef_dis_a: assert property (w1d |=>
    p1_fef_disable == $past(reg_wdata[4])) else $error("fef wrong");
  pwr_loop_a: assert property (w2d |=>
    {p2_power_down, p2_loopback} == {$past(reg_wdata[3]), $past(reg_wdata[0])})
    else $error("pd/lb wrong");
  mdix_mode_a: assert property (w1d |=>
    {p1_auto_mdix_disable, p1_force_mdi} == $past(reg_wdata[2:1]))
    else $error("crossover wrong");

  // Main scenarios reached
  cover property (w2c);
  cover property (p2_autoneg_restart);
  cover property (p1_led == 2'h3);
endmodule

bind ppc_phy_port_control_regs ppc_regs_checker u_chk (.sys_clk, .nrst,
  .reg_wr, .reg_addr, .reg_wdata, .p2_autoneg_en, .p2_speed_100,
  .p2_duplex_full, .p2_advertise, .p1_led, .p2_tx_disable,
  .p2_autoneg_restart, .p1_fef_disable, .p2_power_down, .p2_loopback,
  .p1_auto_mdix_disable, .p1_force_mdi);
`default_nettype wire

// >>> tb/ppc_phy_port_control_regs_tb.sv
/*
  Bench for the PHY control register bank: straps, readback, controls.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ns
`default_nettype none

module ppc_phy_port_control_regs_tb;
  logic sys_clk = 0, nrst = 0, reg_wr, reg_rd;
  logic port1_led_lo_strap, port1_led_hi_strap, mii_valid_strap;
  logic mii_data3_strap, mii_data2_strap, mii_data1_strap;
  logic p1_autoneg_en, p1_force_100, p1_force_full;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d1, d2, dc, c1, c2, an2;
  logic p2_autoneg_en, p2_speed_100, p2_duplex_full;
  logic [4:0] p2_advertise;
  logic [1:0] p1_led_in, p2_led_in, p1_led, p2_led;
  logic p1_tx_disable, p1_autoneg_restart, p1_fef_disable, p1_power_down;
  logic p1_auto_mdix_disable, p1_force_mdi, p1_loopback, p2_tx_disable;
  logic p2_autoneg_restart, p2_fef_disable, p2_power_down, p2_loopback;
  logic p2_auto_mdix_disable, p2_force_mdi;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'h2E106F2A, r;
  int errors = 0, n_tests = 0;

  always #50 sys_clk = ~sys_clk;
  // Controls packed in register order; led and restart checked apart
  assign c1 = {1'b0, p1_tx_disable, 1'b0, p1_fef_disable, p1_power_down,
    p1_auto_mdix_disable, p1_force_mdi, p1_loopback};
  assign c2 = {1'b0, p2_tx_disable, 1'b0, p2_fef_disable, p2_power_down,
    p2_auto_mdix_disable, p2_force_mdi, p2_loopback};
  assign an2 = {p2_autoneg_en, p2_speed_100, p2_duplex_full, p2_advertise};

  ppc_phy_port_control_regs u_ppc_phy_port_control_regs (.sys_clk, .nrst,
    .port1_led_lo_strap, .port1_led_hi_strap, .mii_valid_strap,
    .mii_data3_strap, .mii_data2_strap, .mii_data1_strap, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .p1_autoneg_en, .p1_force_100,
    .p1_force_full, .p2_autoneg_en, .p2_speed_100, .p2_duplex_full,
    .p2_advertise, .p1_led_in, .p2_led_in, .p1_led, .p2_led, .p1_tx_disable,
    .p1_autoneg_restart, .p1_fef_disable, .p1_power_down,
    .p1_auto_mdix_disable, .p1_force_mdi, .p1_loopback, .p2_tx_disable,
    .p2_autoneg_restart, .p2_fef_disable, .p2_power_down,
    .p2_auto_mdix_disable, .p2_force_mdi, .p2_loopback);
  ppc_host_model u_ppc_host_model (.sys_clk, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ppc_host_model.op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_ppc_host_model.op(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle();
    u_ppc_host_model.op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Read data lands on the same edge that takes the strobe
  always @(posedge sys_clk) begin
    if (reg_rd) begin
      #5;
      check(reg_rdata, exp_q.pop_front());
    end
  end
  // Hang guard
  initial begin
    #3000000;
    errors++;
    give_verdict();
  end

  initial begin
    r = rnd();
    {p1_led_in, p2_led_in} = 4'h0;
    {port1_led_lo_strap, port1_led_hi_strap, mii_valid_strap} = r[2:0];
    {mii_data3_strap, mii_data2_strap, mii_data1_strap} = r[5:3];
    repeat (6) @(posedge sys_clk);
    #1 nrst = 1'b1;
    rd(8'h2C, {r[5:3], 5'h1F});
    check({5'h00, p1_autoneg_en, p1_force_100, p1_force_full},
      {5'h00, r[2:0]});
    rd(8'h1D, 8'h00);
    rd(8'h2D, 8'h00);
    rd(8'h3C, 8'h00);
    idle();
    check(an2, {r[5:3], 5'h1F});
    $display("reset and strap test done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      {dc, d1, d2} = r[23:0];
      {p1_led_in, p2_led_in} = r[27:24];
      wr(8'h2C, dc);
      wr(8'h1D, d1);
      wr(8'h2D, d2);
      wr(8'h3D, ~d2);
      rd(8'h2C, dc);
      rd(8'h1D, d1);
      rd(8'h2D, d2);
      rd(8'h3D, 8'h00);
      rd(8'h4A, 8'h00);
      idle();
      check(an2, dc);
      check(c1, d1 & 8'h5F);
      check(c2, d2 & 8'h5F);
      check({6'h00, p1_led}, {6'h00, d1[7] ? 2'h3 : p1_led_in});
      check({6'h00, p2_led}, {6'h00, d2[7] ? 2'h3 : p2_led_in});
    end
    $display("random register test done");
    wr(8'h1D, 8'h20);
    wr(8'h2D, 8'h20);
    idle();
    check({6'h00, p1_autoneg_restart, p2_autoneg_restart}, 8'h01);
    idle();
    check({6'h00, p1_autoneg_restart, p2_autoneg_restart}, 8'h00);
    $display("restart pulse test done");
    give_verdict();
  end
endmodule
`default_nettype wire
